// file: hw/sho_gain_stage.sv
// one channel's gain applier: commit pulse, optional zero-cross deferral
// assumes zc_event is a one-cycle pulse already in the clk domain
`default_nettype none
module sho_gain_stage (
  input wire logic clk,
  input wire logic rst,
  input wire logic commit,
  input wire logic zc_enable,
  input wire logic zc_event,
  input wire logic [sho_pkg::GAIN_W-1:0] gain_in,
  output logic [sho_pkg::GAIN_W-1:0] gain_out,
  output logic waiting
);
  sho_pkg::sho_zc_state_type state_r, state_nxt;
  logic [sho_pkg::GAIN_W-1:0] gain_r, gain_nxt, target_r, target_nxt;

  always_comb begin
    state_nxt = state_r;
    gain_nxt = gain_r;
    target_nxt = target_r;
    case (state_r)
      sho_pkg::SHO_IDLE: begin
        if (commit && !zc_enable) begin
          gain_nxt = gain_in;
        end else if (commit) begin
          target_nxt = gain_in;
          state_nxt = sho_pkg::SHO_WAIT;
        end
      end
      sho_pkg::SHO_WAIT: begin
        // a fresh commit while waiting replaces the target, or applies at once if zero-cross is now off
        if (commit && !zc_enable) begin
          gain_nxt = gain_in;
          state_nxt = sho_pkg::SHO_IDLE;
        end else if (commit) begin
          target_nxt = gain_in;
        end else if (zc_event || !zc_enable) begin
          gain_nxt = target_r;
          state_nxt = sho_pkg::SHO_IDLE;
        end
      end
      default: state_nxt = sho_pkg::SHO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sho_pkg::SHO_IDLE;
      gain_r <= sho_pkg::GAIN_RST;
      target_r <= sho_pkg::GAIN_RST;
    end else begin
      state_r <= state_nxt;
      gain_r <= gain_nxt;
      target_r <= target_nxt;
    end
  end

  assign gain_out = gain_r;
  assign waiting = (state_r == sho_pkg::SHO_WAIT);
endmodule : sho_gain_stage
`default_nettype wire

// file: hw/sho_regs.sv
// apb register bank for the second headphone output pair
// assumes zero-cross comparator levels arrive asynchronously and toggle
// at each crossing; analogue side consumes ctrl directly
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module sho_regs #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [sho_pkg::DATA_W-1:0] pwdata,
  output logic [sho_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] zero_cross_in,
  output sho_pkg::sho_ctrl_type ctrl
);
  if (ADDR_W < 10) begin : g_chk
    $error("sho_regs: ADDR_W must reach byte address of index 0x70");
  end

  localparam logic [ADDR_W-1:0] A_CTRL =
    ADDR_W'({sho_pkg::IDX_OUT_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] A_LVOL =
    ADDR_W'({sho_pkg::IDX_LEFT_VOL, 2'b00});
  localparam logic [ADDR_W-1:0] A_RVOL =
    ADDR_W'({sho_pkg::IDX_RIGHT_VOL, 2'b00});
  localparam logic [ADDR_W-1:0] A_BEEP =
    ADDR_W'({sho_pkg::IDX_BEEP, 2'b00});
  localparam logic [ADDR_W-1:0] A_STAT =
    ADDR_W'({sho_pkg::IDX_STATUS, 2'b00});

  // bus state
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [sho_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
  // control state
  logic lmute_r, lmute_nxt, rmute_r, rmute_nxt;
  logic lzc_r, lzc_nxt, rzc_r, rzc_nxt;
  logic inv_r, inv_nxt, invm_r, invm_nxt, fb_r, fb_nxt;
  logic beep_r, beep_nxt, commit_r, commit_nxt;
  logic [sho_pkg::BEEP_GAIN_W-1:0] bgain_r, bgain_nxt;
  logic [sho_pkg::GAIN_W-1:0] lpend_r, lpend_nxt, rpend_r, rpend_nxt;
  // zero-cross synchronisers; s1 is read only by s2
  logic [1:0] zc_s1_r, zc_s2_r, zc_s3_r, zc_ev;
  logic [1:0] zc_en, waiting;
  logic [sho_pkg::GAIN_W-1:0] act_gain [2];
  logic [sho_pkg::GAIN_W-1:0] pend_gain [2];

  logic setup, wr;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite;

  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = '0;
    if (!setup) begin
      pslverr_nxt = 1'b0;
    end else if (paddr == A_CTRL) begin
      prdata_nxt[sho_pkg::FB_BIT] = fb_r;
    end else if (paddr == A_LVOL) begin
      prdata_nxt[sho_pkg::MUTE_BIT] = lmute_r;
      prdata_nxt[sho_pkg::ZC_BIT] = lzc_r;
      prdata_nxt[sho_pkg::GAIN_LSB +: sho_pkg::GAIN_W] = lpend_r;
    end else if (paddr == A_RVOL) begin
      prdata_nxt[sho_pkg::MUTE_BIT] = rmute_r;
      prdata_nxt[sho_pkg::ZC_BIT] = rzc_r;
      prdata_nxt[sho_pkg::INV_BIT] = inv_r;
      prdata_nxt[sho_pkg::INV_MUTE_BIT] = invm_r;
      prdata_nxt[sho_pkg::GAIN_LSB +: sho_pkg::GAIN_W] = rpend_r;
    end else if (paddr == A_BEEP) begin
      prdata_nxt[sho_pkg::BEEP_EN_BIT] = beep_r;
      prdata_nxt[sho_pkg::BEEP_GAIN_LSB +: sho_pkg::BEEP_GAIN_W] = bgain_r;
    end else if (paddr == A_STAT) begin
      prdata_nxt[0 +: sho_pkg::GAIN_W] = act_gain[0];
      prdata_nxt[sho_pkg::STAT_LWAIT_BIT] = waiting[0];
      prdata_nxt[sho_pkg::STAT_RGAIN_LSB +: sho_pkg::GAIN_W] = act_gain[1];
      prdata_nxt[sho_pkg::STAT_RWAIT_BIT] = waiting[1];
    end else begin
      pslverr_nxt = 1'b1;
    end
  end

  always_comb begin
    lmute_nxt = lmute_r;
    rmute_nxt = rmute_r;
    lzc_nxt = lzc_r;
    rzc_nxt = rzc_r;
    inv_nxt = inv_r;
    invm_nxt = invm_r;
    fb_nxt = fb_r;
    beep_nxt = beep_r;
    bgain_nxt = bgain_r;
    lpend_nxt = lpend_r;
    rpend_nxt = rpend_r;
    commit_nxt = 1'b0;
    if (!wr) begin
      commit_nxt = 1'b0;
    end else if (paddr == A_CTRL) begin
      fb_nxt = pwdata[sho_pkg::FB_BIT];
    end else if (paddr == A_LVOL) begin
      lmute_nxt = pwdata[sho_pkg::MUTE_BIT];
      lzc_nxt = pwdata[sho_pkg::ZC_BIT];
      lpend_nxt = pwdata[sho_pkg::GAIN_LSB +: sho_pkg::GAIN_W];
      commit_nxt = pwdata[sho_pkg::VU_BIT];
    end else if (paddr == A_RVOL) begin
      rmute_nxt = pwdata[sho_pkg::MUTE_BIT];
      rzc_nxt = pwdata[sho_pkg::ZC_BIT];
      inv_nxt = pwdata[sho_pkg::INV_BIT];
      invm_nxt = pwdata[sho_pkg::INV_MUTE_BIT];
      rpend_nxt = pwdata[sho_pkg::GAIN_LSB +: sho_pkg::GAIN_W];
      commit_nxt = pwdata[sho_pkg::VU_BIT];
    end else if (paddr == A_BEEP) begin
      beep_nxt = pwdata[sho_pkg::BEEP_EN_BIT];
      bgain_nxt = pwdata[sho_pkg::BEEP_GAIN_LSB +: sho_pkg::BEEP_GAIN_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      lmute_r <= sho_pkg::MUTE_RST;
      rmute_r <= sho_pkg::MUTE_RST;
      lzc_r <= sho_pkg::ZC_RST;
      rzc_r <= sho_pkg::ZC_RST;
      inv_r <= sho_pkg::INV_RST;
      invm_r <= sho_pkg::INV_MUTE_RST;
      fb_r <= sho_pkg::FB_RST;
      beep_r <= sho_pkg::BEEP_EN_RST;
      bgain_r <= sho_pkg::BEEP_GAIN_RST;
      lpend_r <= sho_pkg::GAIN_RST;
      rpend_r <= sho_pkg::GAIN_RST;
      commit_r <= 1'b0;
      zc_s1_r <= 2'h0;
      zc_s2_r <= 2'h0;
      zc_s3_r <= 2'h0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      lmute_r <= lmute_nxt;
      rmute_r <= rmute_nxt;
      lzc_r <= lzc_nxt;
      rzc_r <= rzc_nxt;
      inv_r <= inv_nxt;
      invm_r <= invm_nxt;
      fb_r <= fb_nxt;
      beep_r <= beep_nxt;
      bgain_r <= bgain_nxt;
      lpend_r <= lpend_nxt;
      rpend_r <= rpend_nxt;
      commit_r <= commit_nxt;
      zc_s1_r <= zero_cross_in;
      zc_s2_r <= zc_s1_r;
      zc_s3_r <= zc_s2_r;
    end
  end

  assign zc_en = {rzc_r, lzc_r};
  assign pend_gain[0] = lpend_r;
  assign pend_gain[1] = rpend_r;

  // commit arrives a cycle after the write, so pending gains are settled
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    assign zc_ev[ch] = zc_s2_r[ch] ^ zc_s3_r[ch];
    sho_gain_stage u_stage (
      .clk(clk),
      .rst(rst),
      .commit(commit_r),
      .zc_enable(zc_en[ch]),
      .zc_event(zc_ev[ch]),
      .gain_in(pend_gain[ch]),
      .gain_out(act_gain[ch]),
      .waiting(waiting[ch])
    );
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ctrl.left_gain = act_gain[0];
  assign ctrl.right_gain = act_gain[1];
  // mute is separate from the polarity bits, so it covers both paths
  assign ctrl.left_mute = lmute_r;
  assign ctrl.right_mute = rmute_r;
  assign ctrl.right_inverter_enable = inv_r;
  assign ctrl.right_inverter_feed_mute = invm_r;
  assign ctrl.pair_ground_feedback_enable = fb_r;
  assign ctrl.beep_inject_enable = beep_r;
  assign ctrl.beep_inject_gain = bgain_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_vals;
    $fell(rst) |-> act_gain[0] == 6'h39 && act_gain[1] == 6'h39 && invm_r
      && !inv_r && !fb_r;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset");

  property p_hold;
    !commit_r && !waiting[0] |=> $stable(act_gain[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("gain moved");

  property p_now;
    commit_r && !lzc_r |=> act_gain[0] == $past(lpend_r);
  endproperty
  a_now: assert property (p_now) else $error("no commit");

  property p_defer;
    commit_r && rzc_r |=> waiting[1] && $stable(act_gain[1]);
  endproperty
  a_defer: assert property (p_defer) else $error("no defer");

  property p_cross;
    waiting[1] && !commit_r && zc_ev[1] |=> !waiting[1];
  endproperty
  a_cross: assert property (p_cross) else $error("cross lost");

  property p_mute;
    wr && paddr == A_RVOL |=> rmute_r == $past(pwdata[sho_pkg::MUTE_BIT]);
  endproperty
  a_mute: assert property (p_mute) else $error("mute");

  property p_fb;
    wr && paddr == A_CTRL |=> ##1 ctrl.pair_ground_feedback_enable
      == $past(pwdata[sho_pkg::FB_BIT], 2);
  endproperty
  a_fb: assert property (p_fb) else $error("feedback");

  property p_beep;
    wr && paddr == A_BEEP |=> beep_r == $past(pwdata[sho_pkg::BEEP_EN_BIT]);
  endproperty
  a_beep: assert property (p_beep) else $error("beep");

  property p_strobe;
    wr && (paddr == A_LVOL || paddr == A_RVOL) && pwdata[sho_pkg::VU_BIT]
      |=> commit_r ##1 (!commit_r && prdata_r[sho_pkg::VU_BIT] == 1'b0);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
endmodule : sho_regs
`default_nettype wire

// file: shared/sho_pkg.sv
// constants and types for the second headphone output control bank
// assumes a 32-bit apb slave; register offsets are word indices
// Notes on behaviour
// - 6-bit gain: 0 min, 111001 unity, all ones max; resets to unity
// - written gains wait pending until a volume commit bit is written as one
// - per-channel zero-cross enable bit 13 defers gain changes to a crossing
// - per-channel mute bit 14; right mute acts on either polarity path
// - feed mute bit 9 routes right stage; resets 1, inverter enable resets 0
// - output control bit 2 enables common-return ground feedback; resets 0
// - beep bit 15 injects right aux input into right output; 3-bit gain
`default_nettype none
package sho_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] IDX_OUT_CTRL = 8'h4c;
  localparam logic [7:0] IDX_LEFT_VOL = 8'h6a;
  localparam logic [7:0] IDX_RIGHT_VOL = 8'h6b;
  localparam logic [7:0] IDX_BEEP = 8'h6f;
  localparam logic [7:0] IDX_STATUS = 8'h70;
  localparam int unsigned MUTE_BIT = 14;
  localparam int unsigned ZC_BIT = 13;
  localparam int unsigned INV_BIT = 10;
  localparam int unsigned INV_MUTE_BIT = 9;
  localparam int unsigned VU_BIT = 8;
  localparam int unsigned GAIN_LSB = 2;
  localparam int unsigned GAIN_W = 6;
  localparam int unsigned FB_BIT = 2;
  localparam int unsigned BEEP_EN_BIT = 15;
  localparam int unsigned BEEP_GAIN_LSB = 5;
  localparam int unsigned BEEP_GAIN_W = 3;
  localparam int unsigned STAT_RGAIN_LSB = 8;
  localparam int unsigned STAT_LWAIT_BIT = 6;
  localparam int unsigned STAT_RWAIT_BIT = 14;
  localparam logic [GAIN_W-1:0] GAIN_RST = 6'h39;
  localparam logic INV_MUTE_RST = 1'b1;
  localparam logic INV_RST = 1'b0;
  localparam logic FB_RST = 1'b0;
  localparam logic [BEEP_GAIN_W-1:0] BEEP_GAIN_RST = 3'h0;
  localparam logic MUTE_RST = 1'b0;
  localparam logic ZC_RST = 1'b0;
  localparam logic BEEP_EN_RST = 1'b0;

  typedef struct packed {
    logic [GAIN_W-1:0] left_gain;
    logic [GAIN_W-1:0] right_gain;
    logic left_mute;
    logic right_mute;
    logic right_inverter_enable;
    logic right_inverter_feed_mute;
    logic pair_ground_feedback_enable;
    logic beep_inject_enable;
    logic [BEEP_GAIN_W-1:0] beep_inject_gain;
  } sho_ctrl_type;

  typedef enum logic {SHO_IDLE, SHO_WAIT} sho_zc_state_type;
endpackage : sho_pkg
`default_nettype wire

// file: sim/second_headphone_output_control_test.sv
// self-checking bench for the second output pair register bank
// assumes sho_regs answers every apb access with one wait-free cycle
`default_nettype none
module second_headphone_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTRL = {2'b00, sho_pkg::IDX_OUT_CTRL, 2'b00};
  localparam logic [11:0] A_LV = {2'b00, sho_pkg::IDX_LEFT_VOL, 2'b00};
  localparam logic [11:0] A_RV = {2'b00, sho_pkg::IDX_RIGHT_VOL, 2'b00};
  localparam logic [11:0] A_BEEP = {2'b00, sho_pkg::IDX_BEEP, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, sho_pkg::IDX_STATUS, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] zero_cross_in = 2'h0;
  sho_pkg::sho_ctrl_type ctrl;
  sho_pkg::sho_ctrl_type exp_c;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  sho_regs #(.ADDR_W(12)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_cross_in(zero_cross_in),
    .ctrl(ctrl)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask : rd

  // commit reaches the active gain within three cycles of the write
  task automatic chk_ctrl;
    repeat (3) @(posedge clk);
    chk(32'(ctrl), 32'(exp_c));
  endtask : chk_ctrl

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    exp_c = '0;
    exp_c.left_gain = 6'h39;
    exp_c.right_gain = 6'h39;
    exp_c.right_inverter_feed_mute = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_ctrl();
    rd(A_LV, 32'h0000_00e4, 1'b0);
    rd(A_RV, 32'h0000_02e4, 1'b0);
    rd(A_CTRL, 32'h0, 1'b0);
    rd(A_BEEP, 32'h0, 1'b0);
    // minimum code left, held pending until the right commit
    wr(A_LV, 32'h0000_0000);
    chk_ctrl();
    wr(A_RV, 32'h0000_03fc);
    exp_c.left_gain = 6'h00;
    exp_c.right_gain = 6'h3f;
    chk_ctrl();
    rd(A_LV, 32'h0, 1'b0);
    rd(A_RV, 32'h0000_02fc, 1'b0);
    // inverting path with both mutes, no commit so gains stay
    wr(A_RV, 32'h0000_44fc);
    wr(A_LV, 32'h0000_4000);
    exp_c.right_mute = 1'b1;
    exp_c.left_mute = 1'b1;
    exp_c.right_inverter_enable = 1'b1;
    exp_c.right_inverter_feed_mute = 1'b0;
    chk_ctrl();
    // capless load: common-return ground feedback enabled
    wr(A_CTRL, 32'h0000_0004);
    exp_c.pair_ground_feedback_enable = 1'b1;
    rd(A_CTRL, 32'h0000_0004, 1'b0);
    wr(A_BEEP, 32'h0000_80e0);
    exp_c.beep_inject_enable = 1'b1;
    exp_c.beep_inject_gain = 3'h7;
    rd(A_BEEP, 32'h0000_80e0, 1'b0);
    chk_ctrl();
    // zero-cross deferral on the left channel
    wr(A_LV, 32'h0000_2140);
    exp_c.left_mute = 1'b0;
    chk_ctrl();
    rd(A_STAT, 32'h0000_3f40, 1'b0);
    zero_cross_in <= 2'h1;
    repeat (8) @(posedge clk);
    exp_c.left_gain = 6'h10;
    chk_ctrl();
    rd(A_STAT, 32'h0000_3f10, 1'b0);
    // right channel deferral; left still has zero-cross set, so it waits too
    wr(A_RV, 32'h0000_2580);
    exp_c.right_mute = 1'b0;
    chk_ctrl();
    rd(A_STAT, 32'h0000_7f50, 1'b0);
    zero_cross_in <= 2'h3;
    repeat (8) @(posedge clk);
    exp_c.right_gain = 6'h20;
    chk_ctrl();
    rd(A_STAT, 32'h0000_2050, 1'b0);
    // clearing zero-cross while waiting applies the target at once
    wr(A_LV, 32'h0000_0040);
    rd(A_STAT, 32'h0000_2010, 1'b0);
    // unmapped place answers with an error and reads zero
    rd(12'h000, 32'h0, 1'b1);
    print_verdict();
  end
endmodule : second_headphone_output_control_test
`default_nettype wire
